// *** design/memory_timing_param_regs.sv ***
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module memory_timing_param_regs (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire mem_timing_pkg::apb_req_s apbReq,
   output mem_timing_pkg::apb_rsp_s apbRsp,
   input wire logic selfRefreshExit,
   input wire logic modeLoad,
   input wire logic activateReq,
   input wire logic [1:0] activateBank,
   input wire logic activateIssue,
   output logic activateAllowed,
   input wire logic staticStart,
   input wire logic [1:0] staticCs,
   input wire logic [4:0] normalWait,
   output logic staticBusy,
   output mem_timing_pkg::dyn_cfg_s [mem_timing_pkg::NUM_DYN_CS-1:0] dynCfg
);
   import mem_timing_pkg::*;

   regs_s st_ff;
   regs_s nxt_st;
   logic access;
   logic pready;
   logic commit;
   logic [NUM_TIMERS-1:0] tmrLoad;
   logic [CNT_W-1:0] tmrValue [NUM_TIMERS];
   logic [NUM_TIMERS-1:0] tmrBusy;
   logic bankClash;

   // =====================================
   // Decoding helpers
   function automatic logic isMapped(input logic [7:0] addr);
      isMapped = (addr == XSR_ADDR) || (addr == RRD_ADDR) || (addr == MRD_ADDR) ||
                 (addr == LONG_WAIT_ADDR) || (addr == LONG_WAIT_EN_ADDR) ||
                 (addr == STATUS_ADDR) ||
                 ((addr[7:4] == DYN_CFG_ADDR[7:4]) && (addr[1:0] == 2'h0));
   endfunction : isMapped

   function automatic logic isDynCfg(input logic [7:0] addr, input int idx);
      isDynCfg = (addr == (DYN_CFG_ADDR + 8'(idx * 4)));
   endfunction : isDynCfg

   // Code n means n+1 cycles (16 times that when scaled); counter holds cycles-1, so an unscaled code loads as is
   function automatic logic [CNT_W-1:0] loadFor(input logic [9:0] code, input logic scaled);
      logic [CNT_W-1:0] wide;
      wide = CNT_W'(code);
      if (scaled) begin
         loadFor = ((wide + 1'b1) << LONG_WAIT_SHIFT) - 1'b1;
      end else begin
         loadFor = wide;
      end
   endfunction : loadFor

   function automatic logic [31:0] cfgToWord(input dyn_cfg_s c);
      logic [31:0] w;
      w = 32'h0;
      w[CFG_PROTECT_POS] = c.writeProtect;
      w[CFG_BUFFER_POS] = c.bufferEnable;
      w[CFG_MAP_HIGH_POS] = c.mapHigh;
      w[CFG_MAP_LOW_POS +: 6] = c.mapLow;
      w[CFG_DEVICE_POS +: 2] = c.memDevice;
      cfgToWord = w;
   endfunction : cfgToWord

   function automatic dyn_cfg_s cfgFromWord(input logic [31:0] w);
      dyn_cfg_s c;
      c.writeProtect = w[CFG_PROTECT_POS];
      c.bufferEnable = w[CFG_BUFFER_POS];
      c.mapHigh = w[CFG_MAP_HIGH_POS];
      c.mapLow = w[CFG_MAP_LOW_POS +: 6];
      c.memDevice = w[CFG_DEVICE_POS +: 2];
      cfgFromWord = c;
   endfunction : cfgFromWord

   // =====================================
   // APB handshake: first access cycle is the wait state
   assign access = apbReq.psel && apbReq.penable;
   assign pready = access && st_ff.waitDone;
   assign commit = pready;

   assign apbRsp.prdata = st_ff.prdata;
   assign apbRsp.pready = pready;
   assign apbRsp.pslverr = access && st_ff.waitDone && st_ff.pslverr;

   // =====================================
   // Next state
   always_comb begin
      nxt_st = st_ff;
      nxt_st.waitDone = access && !st_ff.waitDone;
      if (access && !st_ff.waitDone) begin
         nxt_st.pslverr = !isMapped(apbReq.paddr);
         nxt_st.prdata = 32'h0;
         unique case (apbReq.paddr)
            XSR_ADDR: begin
               nxt_st.prdata[4:0] = st_ff.xsr;
            end
            RRD_ADDR: begin
               nxt_st.prdata[3:0] = st_ff.rrd;
            end
            MRD_ADDR: begin
               nxt_st.prdata[3:0] = st_ff.mrd;
            end
            LONG_WAIT_ADDR: begin
               nxt_st.prdata[9:0] = st_ff.longWait;
            end
            LONG_WAIT_EN_ADDR: begin
               nxt_st.prdata[3:0] = st_ff.longWaitEn;
            end
            STATUS_ADDR: begin
               nxt_st.prdata[NUM_TIMERS-1:0] = tmrBusy;
               nxt_st.prdata[9:8] = st_ff.lastBank;
            end
            default: begin
               for (int i = 0; i < NUM_DYN_CS; i++) begin
                  if (isDynCfg(apbReq.paddr, i)) begin
                     nxt_st.prdata = cfgToWord(st_ff.dyn[i]);
                  end
               end
            end
         endcase
      end
      // Writes take effect only on the completing edge
      if (commit && apbReq.pwrite) begin
         unique case (apbReq.paddr)
            XSR_ADDR: begin
               nxt_st.xsr = apbReq.pwdata[4:0];
            end
            RRD_ADDR: begin
               nxt_st.rrd = apbReq.pwdata[3:0];
            end
            MRD_ADDR: begin
               nxt_st.mrd = apbReq.pwdata[3:0];
            end
            LONG_WAIT_ADDR: begin
               nxt_st.longWait = apbReq.pwdata[9:0];
            end
            LONG_WAIT_EN_ADDR: begin
               nxt_st.longWaitEn = apbReq.pwdata[3:0];
            end
            default: begin
               for (int i = 0; i < NUM_DYN_CS; i++) begin
                  if (isDynCfg(apbReq.paddr, i)) begin
                     nxt_st.dyn[i] = cfgFromWord(apbReq.pwdata);
                  end
               end
            end
         endcase
      end
      if (activateIssue) begin
         nxt_st.lastBank = activateBank;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= '0;
         st_ff.xsr <= XSR_RESET;
         st_ff.rrd <= RRD_RESET;
         st_ff.mrd <= MRD_RESET;
         st_ff.longWait <= LONG_WAIT_RESET;
         st_ff.longWaitEn <= LONG_WAIT_EN_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign dynCfg = st_ff.dyn;

   // =====================================
   // Delay timers, all on sys_clk
   // Values are copied at load, so a register write mid-wait cannot disturb it
   assign tmrLoad[TMR_XSR] = selfRefreshExit;
   assign tmrValue[TMR_XSR] = loadFor(10'(st_ff.xsr), 1'b0);
   assign tmrLoad[TMR_RRD] = activateIssue;
   assign tmrValue[TMR_RRD] = loadFor(10'(st_ff.rrd), 1'b0);
   assign tmrLoad[TMR_MRD] = modeLoad;
   assign tmrValue[TMR_MRD] = loadFor(10'(st_ff.mrd), 1'b0);
   assign tmrLoad[TMR_STATIC] = staticStart;
   assign tmrValue[TMR_STATIC] = st_ff.longWaitEn[staticCs] ?
                                 loadFor(st_ff.longWait, 1'b1) :
                                 CNT_W'(normalWait);

   generate
      for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
         delay_counter u_cnt (
            .sys_clk(sys_clk),
            .rst_b(rst_b),
            .load(tmrLoad[t]),
            .loadValue(tmrValue[t]),
            .busy(tmrBusy[t])
         );
      end
   endgenerate

   // =====================================
   // Activate gate; same-bank activates are not held by the bank-to-bank delay
   assign bankClash = tmrBusy[TMR_RRD] && (activateBank != st_ff.lastBank);
   assign activateAllowed = activateReq && !tmrBusy[TMR_XSR] &&
                            !tmrBusy[TMR_MRD] && !bankClash;
   assign staticBusy = tmrBusy[TMR_STATIC];

   // =====================================
   // Checks
   sequence s_setup;
      apbReq.psel && !apbReq.penable;
   endsequence

   sequence s_access;
      apbReq.psel && apbReq.penable;
   endsequence

   property p_one_wait;
      @(posedge sys_clk) disable iff (!rst_b)
      s_setup ##1 s_access |-> !pready ##1 (!(apbReq.psel && apbReq.penable) || pready);
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("access wait not one cycle");

   property p_xsr_write;
      @(posedge sys_clk) disable iff (!rst_b)
      (commit && apbReq.pwrite && apbReq.paddr == XSR_ADDR) |=> st_ff.xsr == $past(apbReq.pwdata[4:0]);
   endproperty
   a_xsr_write: assert property (p_xsr_write) else $error("delay write lost");

   property p_xsr_run;
      @(posedge sys_clk) disable iff (!rst_b)
      (selfRefreshExit && st_ff.xsr == 5'h03) |=> tmrBusy[TMR_XSR] [*3] ##1 !tmrBusy[TMR_XSR];
   endproperty
   a_xsr_run: assert property (p_xsr_run) else $error("exit delay not four cycles");

   property p_xsr_block;
      @(posedge sys_clk) disable iff (!rst_b)
      (selfRefreshExit && st_ff.xsr != 5'h00) |=> !activateAllowed;
   endproperty
   a_xsr_block: assert property (p_xsr_block) else $error("activate during exit delay");

   property p_rrd_block;
      @(posedge sys_clk) disable iff (!rst_b)
      (activateIssue && st_ff.rrd != 4'h0) |=> (activateBank != $past(activateBank)) |-> !activateAllowed;
   endproperty
   a_rrd_block: assert property (p_rrd_block) else $error("bank-to-bank too short");

   property p_mrd_len;
      @(posedge sys_clk) disable iff (!rst_b)
      (modeLoad && st_ff.mrd == 4'hF) |-> ##15 tmrBusy[TMR_MRD] ##1 !tmrBusy[TMR_MRD] || modeLoad;
   endproperty
   a_mrd_len: assert property (p_mrd_len) else $error("mode load delay not sixteen");

   property p_mrd_block;
      @(posedge sys_clk) disable iff (!rst_b)
      (modeLoad && st_ff.mrd != 4'h0) |=> !activateAllowed;
   endproperty
   a_mrd_block: assert property (p_mrd_block) else $error("activate during mode load delay");

   property p_long_wait;
      @(posedge sys_clk) disable iff (!rst_b)
      (staticStart && st_ff.longWaitEn[staticCs] && st_ff.longWait == 10'h000) |->
         ##15 staticBusy ##1 (!staticBusy || staticStart);
   endproperty
   a_long_wait: assert property (p_long_wait) else $error("long wait not sixteen");

   property p_normal_wait;
      @(posedge sys_clk) disable iff (!rst_b)
      (staticStart && !st_ff.longWaitEn[staticCs] && normalWait == 5'h00) |=> !staticBusy;
   endproperty
   a_normal_wait: assert property (p_normal_wait) else $error("normal wait not used");

endmodule : memory_timing_param_regs

`default_nettype wire

// *** design/mem_timing_pkg.sv ***
package mem_timing_pkg;

   // =====================================
   // Register map (byte addresses)
   localparam logic [7:0] XSR_ADDR = 8'h00;
   localparam logic [7:0] RRD_ADDR = 8'h04;
   localparam logic [7:0] MRD_ADDR = 8'h08;
   localparam logic [7:0] LONG_WAIT_ADDR = 8'h0C;
   localparam logic [7:0] DYN_CFG_ADDR = 8'h10;
   localparam logic [7:0] LONG_WAIT_EN_ADDR = 8'h20;
   localparam logic [7:0] STATUS_ADDR = 8'h24;

   // =====================================
   // Reset values
   localparam logic [4:0] XSR_RESET = 5'h1F;
   localparam logic [3:0] RRD_RESET = 4'hF;
   localparam logic [3:0] MRD_RESET = 4'hF;
   localparam logic [9:0] LONG_WAIT_RESET = 10'h000;
   localparam logic [3:0] LONG_WAIT_EN_RESET = 4'h0;

   // =====================================
   // Field positions of a dynamic configuration word
   localparam int CFG_PROTECT_POS = 20;
   localparam int CFG_BUFFER_POS = 19;
   localparam int CFG_MAP_HIGH_POS = 14;
   localparam int CFG_MAP_LOW_POS = 7;
   localparam int CFG_DEVICE_POS = 3;

   // =====================================
   // Counting
   localparam int CNT_W = 14;
   localparam int LONG_WAIT_SHIFT = 4;
   localparam int NUM_DYN_CS = 4;
   localparam int NUM_TIMERS = 4;
   localparam int TMR_XSR = 0;
   localparam int TMR_RRD = 1;
   localparam int TMR_MRD = 2;
   localparam int TMR_STATIC = 3;

   // =====================================
   // Carriers
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_s;

   typedef struct packed {
      logic writeProtect;
      logic bufferEnable;
      logic mapHigh;
      logic [5:0] mapLow;
      logic [1:0] memDevice;
   } dyn_cfg_s;

   typedef struct packed {
      logic [4:0] xsr;
      logic [3:0] rrd;
      logic [3:0] mrd;
      logic [9:0] longWait;
      dyn_cfg_s [NUM_DYN_CS-1:0] dyn;
      logic [3:0] longWaitEn;
      logic [1:0] lastBank;
      logic waitDone;
      logic [31:0] prdata;
      logic pslverr;
   } regs_s;

   typedef struct packed {
      logic [CNT_W-1:0] count;
   } cnt_s;

endpackage : mem_timing_pkg

// *** design/delay_counter.sv ***
`timescale 1ns/100ps
`default_nettype none

module delay_counter (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic load,
   input wire logic [mem_timing_pkg::CNT_W-1:0] loadValue,
   output logic busy
);
   import mem_timing_pkg::*;

   cnt_s st_ff;
   cnt_s nxt_st;

   // =====================================
   // Down-counter, reload wins over the decrement
   always_comb begin
      nxt_st = st_ff;
      if (load) begin
         nxt_st.count = loadValue;
      end else if (st_ff.count != '0) begin
         nxt_st.count = st_ff.count - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign busy = (st_ff.count != '0);

endmodule : delay_counter

`default_nettype wire

// *** testbench/mem_cmd_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// =====================================
// Controller-side command source
module mem_cmd_model (
   input wire logic go,
   input wire logic [1:0] kind,
   input wire logic activateAllowed,
   output logic selfRefreshExit,
   output logic modeLoad,
   output logic activateIssue,
   output logic staticStart
);
   // One pulse per bench request, as long as go is high
   assign selfRefreshExit = go && kind == 2'h0;
   assign modeLoad = go && kind == 2'h1;
   // Dynamic commands carry no chip select: one timing set for all
   assign activateIssue = go && kind == 2'h2 && activateAllowed;
   assign staticStart = go && kind == 2'h3;
endmodule : mem_cmd_model

`default_nettype wire

// *** testbench/memory_timing_param_regs_bench.sv ***
`timescale 1ns/100ps
`default_nettype none

module memory_timing_param_regs_bench;
   import mem_timing_pkg::*;

   logic sys_clk;
   logic rst_b;
   apb_req_s apbReq;
   apb_rsp_s apbRsp;
   logic go, activateReq, activateIssue, activateAllowed, staticBusy;
   logic selfRefreshExit, modeLoad, staticStart, lastErr;
   logic [1:0] kind, activateBank, staticCs;
   logic [4:0] normalWait;
   dyn_cfg_s [NUM_DYN_CS-1:0] dynCfg;
   logic [32:0] rdQ[$];
   int durQ[$];
   int busyQ[$];
   int n_fail, num_checks, cycles, blk, sb;

   memory_timing_param_regs u_dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp),
      .selfRefreshExit(selfRefreshExit), .modeLoad(modeLoad), .activateReq(activateReq),
      .activateBank(activateBank), .activateIssue(activateIssue), .activateAllowed(activateAllowed),
      .staticStart(staticStart), .staticCs(staticCs), .normalWait(normalWait),
      .staticBusy(staticBusy), .dynCfg(dynCfg));

   mem_cmd_model u_cmd (
      .go(go), .kind(kind), .activateAllowed(activateAllowed), .selfRefreshExit(selfRefreshExit),
      .modeLoad(modeLoad), .activateIssue(activateIssue), .staticStart(staticStart));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // =====================================
   // Checking
   task automatic cmpVal(input logic [32:0] got, input logic [32:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask : cmpVal

   task automatic cmpDur(input int got, input int exp, input string what);
      num_checks++;
      if (got != exp) begin
         n_fail++;
         $display("unexpected at %0t: %s lasted %0d expected %0d", $time, what, got, exp);
      end
   endtask : cmpDur

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test

   // Monitor: blocked and busy stretches end a result
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 60000) begin
         n_fail++;
         $display("unexpected at %0t: run too long", $time);
         end_of_test();
      end
      if (apbReq.psel && apbReq.penable && apbRsp.pready === 1'b1 && !apbReq.pwrite) begin
         cmpVal({apbRsp.pslverr, apbRsp.prdata}, rdQ.pop_front(), "read");
      end
      if (activateReq && activateAllowed !== 1'b1) begin
         blk++;
      end else if (blk > 0) begin
         cmpDur(blk, durQ.size() ? durQ.pop_front() : -1, "activate hold");
         blk = 0;
      end
      if (staticBusy === 1'b1) begin
         sb++;
      end else if (sb > 0) begin
         cmpDur(sb, busyQ.size() ? busyQ.pop_front() : -1, "static wait");
         sb = 0;
      end
   end

   // =====================================
   // Drivers
   task automatic apb(input logic w, input logic [7:0] a, input logic [32:0] e);
      int n;
      n = 0;
      @(posedge sys_clk);
      apbReq.psel <= 1'b1;
      apbReq.penable <= 1'b0;
      apbReq.pwrite <= w;
      apbReq.paddr <= a;
      apbReq.pwdata <= e[31:0];
      if (!w) rdQ.push_back(e);
      @(posedge sys_clk);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (apbRsp.pready !== 1'b1);
      lastErr = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      cmpDur(n, 2, "access cycles");
   endtask : apb

   task automatic trig(input logic [1:0] k, input int expLen);
      @(posedge sys_clk);
      go <= 1'b1;
      kind <= k;
      if (expLen > 0 && k == 2'h3) busyQ.push_back(expLen);
      else if (expLen > 0) durQ.push_back(expLen);
      @(posedge sys_clk);
      go <= 1'b0;
   endtask : trig

   task automatic settle();
      while (durQ.size() + busyQ.size() > 0) @(posedge sys_clk);
      repeat (2) @(posedge sys_clk);
   endtask : settle

   function automatic int pick(input int j, input int top);
      return j == 0 ? 2 : j == 1 ? top - 1 : j == 2 ? top : $urandom_range(top - 1, 3);
   endfunction : pick

   // =====================================
   // Main sequence
   initial begin
      logic [31:0] d;
      int c;
      apbReq = '0;
      {go, kind, activateReq, activateBank, staticCs, normalWait} = '0;
      rst_b = 1'b0;
      {n_fail, num_checks, cycles, blk, sb} = '0;
      void'($urandom(78));
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      apb(1'b0, XSR_ADDR, 33'h0_0000_001F);
      apb(1'b0, RRD_ADDR, 33'h0_0000_000F);
      apb(1'b0, MRD_ADDR, 33'h0_0000_000F);
      apb(1'b0, LONG_WAIT_ADDR, 33'h0_0000_0000);
      apb(1'b1, 8'h28, 33'h0_1234_5678);
      cmpVal({32'h0, lastErr}, 33'h1, "unmapped write");
      apb(1'b0, 8'h28, 33'h1_0000_0000);
      for (int i = 0; i < 4; i++) begin
         d = $urandom() & 32'h0018_5F98;
         apb(1'b1, DYN_CFG_ADDR + 8'(4 * i), {1'b0, d});
         apb(1'b0, DYN_CFG_ADDR + 8'(4 * i), {1'b0, d});
         cmpVal({22'h0, dynCfg[i]}, {22'h0, d[20], d[19], d[14], d[12:7], d[4:3]}, "config");
      end
      // Timing changes only while no command is outstanding, except the last long wait rewrite during a static wait
      activateReq <= 1'b1;
      for (int j = 0; j < 4; j++) begin
         c = pick(j, 31);
         apb(1'b1, XSR_ADDR, 33'(c));
         apb(1'b0, XSR_ADDR, 33'(c));
         trig(2'h0, c);
         settle();
         c = pick(j, 15);
         apb(1'b1, MRD_ADDR, 33'(c));
         trig(2'h1, c);
         settle();
         c = pick(j, 15);
         apb(1'b1, RRD_ADDR, 33'(c));
         apb(1'b0, RRD_ADDR, 33'(c));
         activateBank <= 2'h2;
         trig(2'h2, 0);
         @(posedge sys_clk);
         cmpVal(33'(activateAllowed), 33'h1, "same bank");
         activateBank <= 2'h3;
         durQ.push_back(c - 1);
         settle();
      end
      activateReq <= 1'b0;
      apb(1'b1, LONG_WAIT_EN_ADDR, 33'h5);
      for (int j = 0; j < 3; j++) begin
         c = j == 0 ? 0 : j == 1 ? $urandom_range(8, 1) : 1023;
         apb(1'b1, LONG_WAIT_ADDR, 33'(c));
         staticCs <= 2'(2 * (j % 2));
         trig(2'h3, (c + 1) * 16 - 1);
         settle();
      end
      staticCs <= 2'h1;
      normalWait <= 5'h13;
      trig(2'h3, 19);
      settle();
      apb(1'b1, LONG_WAIT_ADDR, 33'h1);
      staticCs <= 2'h2;
      trig(2'h3, 31);
      apb(1'b1, LONG_WAIT_ADDR, 33'h0);
      settle();
      trig(2'h3, 15);
      settle();
      end_of_test();
   end
endmodule : memory_timing_param_regs_bench

`default_nettype wire
